//--- pcd_cmp.sv
`timescale 1ns/1ps
// Byte-wise compare of two words over the low n_bytes lanes
module pcd_cmp (
    // Operands
    input wire logic [63:0] a,
    input wire logic [63:0] b,
    input wire logic [3:0] n_bytes,
    // Result
    output logic mis,
    output logic [2:0] idx
);
    // Lowest differing lane wins, so the reported offset never overshoots
    always_comb begin
        mis = 1'b0;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if ((4'(i) < n_bytes) && (a[8*i +: 8] != b[8*i +: 8])) begin
                mis = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule

//--- pcd_defines.svh
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH
// APB register byte offsets
`define PCD_A_CTRL 8'h00
`define PCD_A_FLAGS 8'h04
`define PCD_A_SRC1 8'h08
`define PCD_A_SRC2 8'h0C
`define PCD_A_PATLO 8'h10
`define PCD_A_PATHI 8'h14
`define PCD_A_SIZE 8'h18
`define PCD_A_EXP 8'h1C
`define PCD_A_DREC 8'h20
`define PCD_A_DMAX 8'h24
`define PCD_A_CREC 8'h28
`define PCD_A_STAT 8'h2C
`define PCD_A_BDONE 8'h30
`define PCD_A_FADDR 8'h34
`define PCD_A_DSIZE 8'h38
`define PCD_A_ISTAT 8'h3C
`define PCD_A_IMASK 8'h40
// Flag bit positions
`define PCD_F_CRAV 0
`define PCD_F_RCR 1
`define PCD_F_CHK 2
// Completion status codes
`define PCD_S_NONE 8'h00
`define PCD_S_OK 8'h01
`define PCD_S_FPRED 8'h02
`define PCD_S_PF 8'h03
`define PCD_S_SIZE 8'h10
`define PCD_S_ALIGN 8'h11
`define PCD_S_OVLP 8'h12
`define PCD_S_FLAGS 8'h13
// Geometry
`define PCD_WORD_B 32'h0000_0008
`define PCD_ENTRY_B 32'h0000_0010
`define PCD_ALIGN_M 32'h0000_0007
`define PCD_DELTA_MAX_OFF 32'h0007_FFF8
`define PCD_CR_W1 32'h0000_0008
`define PCD_CR_W2 32'h0000_0010
`endif

//--- pcd_engine.sv
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pcd_defines.svh"
module pcd_engine (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory fabric port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [63:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_fault,
    input wire logic [63:0] mem_rdata,
    // Interrupt
    output logic irq
);
    // Descriptor and interrupt registers
    logic [2:0] ctrl_op_r, ctrl_op_nxt;
    logic start_r, start_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic [31:0] src1_r, src1_nxt, src2_r, src2_nxt, size_r, size_nxt;
    logic [63:0] pat_r, pat_nxt;
    logic [7:0] exp_r, exp_nxt;
    logic [31:0] drec_r, drec_nxt, dmax_r, dmax_nxt, crec_r, crec_nxt;
    logic [1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
    // Engine state
    pcd_pkg::pcd_st_e st_r, st_nxt;
    pcd_pkg::pcd_op_e op_r, op_nxt;
    logic [31:0] pos_r, pos_nxt, dcnt_r, dcnt_nxt, bdone_r, bdone_nxt;
    logic [31:0] faddr_r, faddr_nxt;
    logic [63:0] w1_r, w1_nxt, w2_r, w2_nxt;
    logic [7:0] status_r, status_nxt;
    logic result_r, result_nxt, busy_r, busy_nxt;
    logic mreq_r, mreq_nxt, mwe_r, mwe_nxt;
    logic [31:0] maddr_r, maddr_nxt;
    logic [63:0] mwd_r, mwd_nxt;
    logic [1:0] ev;
    logic hit, setup, cmp_mis;
    logic [2:0] cmp_idx;
    logic [3:0] cmp_n;
    logic [31:0] left;
    logic [7:0] fin_st;

    // Word-aligned check, used for every alignment test
    function automatic logic unal(input logic [31:0] v);
        return (v & `PCD_ALIGN_M) != 32'h0;
    endfunction

    // Final status after check-result mapping, applied for every operation
    function automatic logic [7:0] map_st(input logic [7:0] s, input logic res,
                                          input logic chk, input logic e0);
        if (s == `PCD_S_OK && chk && (e0 != res))
            return `PCD_S_FPRED;
        return s;
    endfunction

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign mem_req = mreq_r;
    assign mem_we = mwe_r;
    assign mem_addr = maddr_r;
    assign mem_wdata = mwd_r;
    assign hit = mreq_r && mem_ack;
    assign setup = psel && !penable;
    assign left = size_r - pos_r;
    assign cmp_n = (left >= `PCD_WORD_B) ? 4'h8 : left[3:0];
    assign fin_st = map_st(status_r, result_r, flags_r[`PCD_F_CHK], exp_r[0]);

    pcd_cmp u_cmp (
        .a(w1_r),
        .b(w2_r),
        .n_bytes(cmp_n),
        .mis(cmp_mis),
        .idx(cmp_idx)
    );

    // APB: decode in setup, answer with pready in the single access cycle
    always_comb begin
        ctrl_op_nxt = ctrl_op_r;
        start_nxt = 1'b0;
        flags_nxt = flags_r;
        src1_nxt = src1_r;
        src2_nxt = src2_r;
        size_nxt = size_r;
        pat_nxt = pat_r;
        exp_nxt = exp_r;
        drec_nxt = drec_r;
        dmax_nxt = dmax_r;
        crec_nxt = crec_r;
        imask_nxt = imask_r;
        prdata_nxt = prdata_r;
        pready_nxt = setup;
        pslverr_nxt = 1'b0;
        // Set wins over a same-cycle one-to-clear
        ist_nxt = ist_r | ev;
        if (setup) begin
            prdata_nxt = 32'h0;
            unique case (paddr)
                `PCD_A_CTRL: prdata_nxt = {28'h0, ctrl_op_r, busy_r};
                `PCD_A_FLAGS: prdata_nxt = {29'h0, flags_r};
                `PCD_A_SRC1: prdata_nxt = src1_r;
                `PCD_A_SRC2: prdata_nxt = src2_r;
                `PCD_A_PATLO: prdata_nxt = pat_r[31:0];
                `PCD_A_PATHI: prdata_nxt = pat_r[63:32];
                `PCD_A_SIZE: prdata_nxt = size_r;
                `PCD_A_EXP: prdata_nxt = {24'h0, exp_r};
                `PCD_A_DREC: prdata_nxt = drec_r;
                `PCD_A_DMAX: prdata_nxt = dmax_r;
                `PCD_A_CREC: prdata_nxt = crec_r;
                `PCD_A_STAT: prdata_nxt = {23'h0, result_r, status_r};
                `PCD_A_BDONE: prdata_nxt = bdone_r;
                `PCD_A_FADDR: prdata_nxt = faddr_r;
                `PCD_A_DSIZE: prdata_nxt = dcnt_r;
                `PCD_A_ISTAT: prdata_nxt = {30'h0, ist_r};
                `PCD_A_IMASK: prdata_nxt = {30'h0, imask_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
        // Writes land at the access edge; only the start bit is ignored while busy
        if (psel && penable && pwrite && pready_r && !pslverr_r) begin
            unique case (paddr)
                `PCD_A_CTRL: begin
                    ctrl_op_nxt = pwdata[3:1];
                    start_nxt = pwdata[0] && !busy_r;
                end
                `PCD_A_FLAGS: flags_nxt = pwdata[2:0];
                `PCD_A_SRC1: src1_nxt = pwdata;
                `PCD_A_SRC2: src2_nxt = pwdata;
                `PCD_A_PATLO: pat_nxt[31:0] = pwdata;
                `PCD_A_PATHI: pat_nxt[63:32] = pwdata;
                `PCD_A_SIZE: size_nxt = pwdata;
                `PCD_A_EXP: exp_nxt = pwdata[7:0];
                `PCD_A_DREC: drec_nxt = pwdata;
                `PCD_A_DMAX: dmax_nxt = pwdata;
                `PCD_A_CREC: crec_nxt = pwdata;
                `PCD_A_ISTAT: ist_nxt = (ist_r & ~pwdata[1:0]) | ev;
                `PCD_A_IMASK: imask_nxt = pwdata[1:0];
                default: ;
            endcase
        end
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_op_r <= 3'h0;
            start_r <= 1'b0;
            flags_r <= 3'h0;
            src1_r <= 32'h0;
            src2_r <= 32'h0;
            size_r <= 32'h0;
            pat_r <= 64'h0;
            exp_r <= 8'h0;
            drec_r <= 32'h0;
            dmax_r <= 32'h0;
            crec_r <= 32'h0;
            ist_r <= 2'h0;
            imask_r <= 2'h0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_op_r <= ctrl_op_nxt;
            start_r <= start_nxt;
            flags_r <= flags_nxt;
            src1_r <= src1_nxt;
            src2_r <= src2_nxt;
            size_r <= size_nxt;
            pat_r <= pat_nxt;
            exp_r <= exp_nxt;
            drec_r <= drec_nxt;
            dmax_r <= dmax_nxt;
            crec_r <= crec_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Engine: one memory access per state, request dropped a cycle between
    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        pos_nxt = pos_r;
        dcnt_nxt = dcnt_r;
        bdone_nxt = bdone_r;
        faddr_nxt = faddr_r;
        w1_nxt = w1_r;
        w2_nxt = w2_r;
        status_nxt = status_r;
        result_nxt = result_r;
        busy_nxt = busy_r;
        ev = 2'h0;
        mwe_nxt = 1'b0;
        maddr_nxt = maddr_r;
        mwd_nxt = 64'h0;
        unique case (st_r)
            pcd_pkg::S_IDLE: if (start_r) begin
                op_nxt = pcd_pkg::pcd_op_e'(ctrl_op_r[1:0]);
                busy_nxt = 1'b1;
                pos_nxt = 32'h0;
                dcnt_nxt = 32'h0;
                bdone_nxt = 32'h0;
                faddr_nxt = 32'h0;
                result_nxt = 1'b0;
                status_nxt = `PCD_S_OK;
                w2_nxt = pat_r;
                st_nxt = pcd_pkg::S_CR0;
                if (!flags_r[`PCD_F_CRAV] || !flags_r[`PCD_F_RCR]) begin
                    status_nxt = `PCD_S_FLAGS;
                    st_nxt = pcd_pkg::S_DONE;
                end else if (op_nxt == pcd_pkg::PCD_OP_NONE)
                    status_nxt = `PCD_S_FLAGS;
                else if (op_nxt == pcd_pkg::PCD_OP_MK && (unal(src1_r) ||
                         unal(src2_r) || unal(size_r)))
                    status_nxt = `PCD_S_ALIGN;
                else if (op_nxt == pcd_pkg::PCD_OP_MK && size_r > `PCD_DELTA_MAX_OFF)
                    status_nxt = `PCD_S_SIZE;
                else if (op_nxt == pcd_pkg::PCD_OP_AP && (unal(src2_r) || unal(size_r)))
                    status_nxt = `PCD_S_ALIGN;
                else if (op_nxt == pcd_pkg::PCD_OP_AP && dmax_r != 32'h0 &&
                         size_r != 32'h0 && drec_r < src2_r + size_r &&
                         src2_r < drec_r + dmax_r)
                    status_nxt = `PCD_S_OVLP;
                else if (op_nxt == pcd_pkg::PCD_OP_AP)
                    st_nxt = (dmax_r == 32'h0) ? pcd_pkg::S_CR0 : pcd_pkg::S_AROF;
                else if (size_r != 32'h0)
                    st_nxt = pcd_pkg::S_RD1;
                maddr_nxt = src1_r;
            end
            pcd_pkg::S_RD1: if (hit) begin
                w1_nxt = mem_rdata;
                st_nxt = (op_r == pcd_pkg::PCD_OP_MK) ? pcd_pkg::S_RD2 : pcd_pkg::S_CMP;
                // A faulting read keeps its address for the record
                maddr_nxt = mem_fault ? maddr_r : src2_r + pos_r;
                if (mem_fault)
                    st_nxt = pcd_pkg::S_PF;
            end
            pcd_pkg::S_RD2: if (hit) begin
                w2_nxt = mem_rdata;
                st_nxt = mem_fault ? pcd_pkg::S_PF : pcd_pkg::S_CMP;
            end
            pcd_pkg::S_CMP: begin
                if (cmp_mis && op_r == pcd_pkg::PCD_OP_PAT) begin
                    result_nxt = 1'b1;
                    bdone_nxt = pos_r + {29'h0, cmp_idx};
                    st_nxt = pcd_pkg::S_CR0;
                end else if (cmp_mis && dcnt_r + `PCD_ENTRY_B > dmax_r) begin
                    status_nxt = `PCD_S_SIZE;
                    bdone_nxt = pos_r;
                    st_nxt = pcd_pkg::S_CR0;
                end else if (cmp_mis) begin
                    st_nxt = pcd_pkg::S_WOFF;
                    maddr_nxt = drec_r + dcnt_r;
                end else if (left <= `PCD_WORD_B) begin
                    bdone_nxt = size_r;
                    st_nxt = pcd_pkg::S_CR0;
                end else begin
                    pos_nxt = pos_r + `PCD_WORD_B;
                    maddr_nxt = src1_r + pos_nxt;
                    st_nxt = pcd_pkg::S_RD1;
                end
            end
            pcd_pkg::S_WOFF: begin
                mwe_nxt = 1'b1;
                mwd_nxt = {32'h0, pos_r};
                if (hit) begin
                    maddr_nxt = maddr_r + `PCD_WORD_B;
                    st_nxt = pcd_pkg::S_WVAL;
                end
            end
            pcd_pkg::S_WVAL: begin
                mwe_nxt = 1'b1;
                mwd_nxt = w2_r;
                if (hit) begin
                    dcnt_nxt = dcnt_r + `PCD_ENTRY_B;
                    result_nxt = 1'b1;
                    pos_nxt = pos_r + `PCD_WORD_B;
                    maddr_nxt = src1_r + pos_nxt;
                    bdone_nxt = pos_nxt;
                    st_nxt = (pos_nxt >= size_r) ? pcd_pkg::S_CR0 : pcd_pkg::S_RD1;
                end
            end
            pcd_pkg::S_AROF: begin
                maddr_nxt = drec_r + dcnt_r;
                if (hit) begin
                    w1_nxt = mem_rdata;
                    maddr_nxt = mem_fault ? maddr_r : maddr_r + `PCD_WORD_B;
                    st_nxt = mem_fault ? pcd_pkg::S_PF : pcd_pkg::S_ARVL;
                end
            end
            pcd_pkg::S_ARVL: if (hit) begin
                w2_nxt = mem_rdata;
                maddr_nxt = mem_fault ? maddr_r : src2_r + w1_r[31:0];
                st_nxt = mem_fault ? pcd_pkg::S_PF : pcd_pkg::S_AW;
            end
            pcd_pkg::S_AW: begin
                mwe_nxt = 1'b1;
                mwd_nxt = w2_r;
                if (hit && mem_fault)
                    st_nxt = pcd_pkg::S_PF;
                else if (hit) begin
                    dcnt_nxt = dcnt_r + `PCD_ENTRY_B;
                    bdone_nxt = size_r;
                    st_nxt = (dcnt_nxt >= dmax_r) ? pcd_pkg::S_CR0 : pcd_pkg::S_AROF;
                end
            end
            pcd_pkg::S_PF: begin
                result_nxt = 1'b0;
                status_nxt = `PCD_S_PF;
                faddr_nxt = maddr_r;
                bdone_nxt = (op_r == pcd_pkg::PCD_OP_AP) ? 32'h0 : pos_r;
                st_nxt = pcd_pkg::S_CR0;
            end
            pcd_pkg::S_CR0: begin
                mwe_nxt = 1'b1;
                maddr_nxt = crec_r;
                mwd_nxt = {bdone_r, 16'h0, 7'h0, result_r, fin_st};
                if (hit) begin
                    maddr_nxt = crec_r + `PCD_CR_W1;
                    st_nxt = pcd_pkg::S_CR1;
                end
            end
            pcd_pkg::S_CR1: begin
                mwe_nxt = 1'b1;
                mwd_nxt = {32'h0, faddr_r};
                if (hit) begin
                    maddr_nxt = crec_r + `PCD_CR_W2;
                    st_nxt = pcd_pkg::S_CR2;
                end
            end
            pcd_pkg::S_CR2: begin
                mwe_nxt = 1'b1;
                mwd_nxt = {32'h0, dcnt_r};
                if (hit) begin
                    status_nxt = fin_st;
                    st_nxt = pcd_pkg::S_DONE;
                end
            end
            pcd_pkg::S_DONE: begin
                busy_nxt = 1'b0;
                ev[0] = 1'b1;
                ev[1] = status_r >= `PCD_S_PF;
                st_nxt = pcd_pkg::S_IDLE;
            end
            default: st_nxt = pcd_pkg::S_IDLE;
        endcase
        // Memory states keep the request up until acknowledged
        mreq_nxt = !hit && (st_r != pcd_pkg::S_IDLE) && (st_r != pcd_pkg::S_CMP) &&
                   (st_r != pcd_pkg::S_PF) && (st_r != pcd_pkg::S_DONE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= pcd_pkg::S_IDLE;
            op_r <= pcd_pkg::PCD_OP_NONE;
            pos_r <= 32'h0;
            dcnt_r <= 32'h0;
            bdone_r <= 32'h0;
            faddr_r <= 32'h0;
            w1_r <= 64'h0;
            w2_r <= 64'h0;
            status_r <= `PCD_S_NONE;
            result_r <= 1'b0;
            busy_r <= 1'b0;
            mreq_r <= 1'b0;
            mwe_r <= 1'b0;
            maddr_r <= 32'h0;
            mwd_r <= 64'h0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            pos_r <= pos_nxt;
            dcnt_r <= dcnt_nxt;
            bdone_r <= bdone_nxt;
            faddr_r <= faddr_nxt;
            w1_r <= w1_nxt;
            w2_r <= w2_nxt;
            status_r <= status_nxt;
            result_r <= result_nxt;
            busy_r <= busy_nxt;
            mreq_r <= mreq_nxt && st_nxt == st_r;
            mwe_r <= mwe_nxt;
            maddr_r <= maddr_nxt;
            mwd_r <= mwd_nxt;
        end
    end

    // Checks on the engine
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pat_mis;
        st_r == pcd_pkg::S_CMP && op_r == pcd_pkg::PCD_OP_PAT && cmp_mis;
    endsequence
    sequence s_fault;
        hit && mem_fault && (st_r == pcd_pkg::S_RD1 || st_r == pcd_pkg::S_AW);
    endsequence
    a_pattern_word:
        assert property (st_r == pcd_pkg::S_CMP && op_r == pcd_pkg::PCD_OP_PAT
            |-> w2_r == pat_r) else $error("pattern word not descriptor pattern");
    a_tail_bytes:
        assert property (st_r == pcd_pkg::S_CMP && size_r - pos_r < 32'h8
            |-> 32'(cmp_n) == size_r - pos_r) else $error("tail byte count wrong");
    a_mis_result:
        assert property (s_pat_mis |=> result_r ##1 st_r == pcd_pkg::S_CR0)
            else $error("mismatch not reported");
    a_mis_offset:
        assert property (s_pat_mis |=> bdone_r <= $past(pos_r) + 32'h7)
            else $error("bytes completed past difference");
    a_fault_result:
        assert property (s_fault |=> ##1 !result_r && status_r == `PCD_S_PF)
            else $error("fault not reported with result 0");
    a_fault_addr:
        assert property (s_fault |=> ##1 faddr_r == $past(maddr_r, 2))
            else $error("fault address lost");
    a_check_map:
        assert property (st_r == pcd_pkg::S_CR0 && status_r == `PCD_S_OK &&
            flags_r[`PCD_F_CHK] && exp_r[0] != result_r |-> mem_wdata[7:0] == `PCD_S_FPRED
            || !mreq_r) else $error("false predicate not mapped");
    a_size_limit:
        assert property (st_r == pcd_pkg::S_IDLE && start_r && flags_r[1:0] == 2'h3 &&
            ctrl_op_r[1:0] == 2'h2 && !unal(src1_r) && !unal(src2_r) && !unal(size_r) &&
            size_r > `PCD_DELTA_MAX_OFF |=> status_r == `PCD_S_SIZE)
            else $error("oversize delta creation accepted");
    a_overlap_err:
        assert property (st_r == pcd_pkg::S_IDLE && status_r == `PCD_S_OVLP |-> !busy_r)
            else $error("overlap error left engine busy");
    a_apply_step:
        assert property (st_r == pcd_pkg::S_AW && hit && !mem_fault |=>
            dcnt_r == $past(dcnt_r) + 32'h10) else $error("apply did not advance");
endmodule

//--- pcd_mem.sv
`timescale 1ns/1ps
// System memory model behind the fabric port
module pcd_mem (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fabric port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [63:0] mem_wdata,
    output logic mem_ack,
    output logic mem_fault,
    output logic [63:0] mem_rdata,
    // Test controls
    input wire logic [31:0] fault_addr,
    input wire logic [1:0] slow
);
    logic [63:0] m [logic [28:0]];
    logic [63:0] rd;
    logic [1:0] w;
    // Data lines show no stale value outside an answer
    assign mem_rdata = mem_ack ? rd : ~rd;
    // One access at a time, answered after slow wait cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_fault <= 1'b0;
            w <= 2'h0;
            rd <= 64'h0;
        end else begin
            mem_ack <= 1'b0;
            if (mem_req && !mem_ack && w < slow) begin
                w <= w + 2'h1;
            end else if (mem_req && !mem_ack) begin
                w <= 2'h0;
                mem_ack <= 1'b1;
                // Only reads fault; record writes would ignore it anyway
                mem_fault <= !mem_we && mem_addr[31:3] == fault_addr[31:3];
                rd <= m.exists(mem_addr[31:3]) ? m[mem_addr[31:3]] : 64'h0;
                if (mem_we) begin
                    m[mem_addr[31:3]] = mem_wdata;
                end
            end
        end
    end
endmodule

//--- pcd_pkg.sv
package pcd_pkg;
    typedef enum logic [1:0] {
        PCD_OP_NONE = 2'h0,
        PCD_OP_PAT = 2'h1,
        PCD_OP_MK = 2'h2,
        PCD_OP_AP = 2'h3
    } pcd_op_e;
    typedef enum logic [13:0] {
        S_IDLE = 14'h0001, S_RD1 = 14'h0002, S_RD2 = 14'h0004,
        S_CMP = 14'h0008, S_WOFF = 14'h0010, S_WVAL = 14'h0020,
        S_AROF = 14'h0040, S_ARVL = 14'h0080, S_AW = 14'h0100,
        S_PF = 14'h0200, S_CR0 = 14'h0400, S_CR1 = 14'h0800,
        S_CR2 = 14'h1000, S_DONE = 14'h2000
    } pcd_st_e;
endpackage

//--- test_pattern_compare_delta_ops.sv
`timescale 1ns/1ps
`include "pcd_defines.svh"
// Self-checking bench for the compare and delta engine
module test_pattern_compare_delta_ops;
    localparam logic [31:0] CR = 32'h0000_0100;
    localparam logic [63:0] MM = 64'hFFFF_FFFF_0000_01FF;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_addr, fault_addr = 32'hFFFF_FFF8, r;
    logic pready, pslverr, mem_req, mem_we, mem_ack, mem_fault, irq;
    logic [63:0] mem_wdata, mem_rdata, pat, n;
    logic [1:0] slow = 2'h0;
    logic [127:0] q [$];
    logic [127:0] nt;
    int fails = 0, checks_done = 0;
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    pcd_engine pcd_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_fault(mem_fault), .mem_rdata(mem_rdata), .irq(irq));
    pcd_mem pcd_mem_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_fault(mem_fault), .mem_rdata(mem_rdata), .fault_addr(fault_addr), .slow(slow));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle, so a following call never drives psel twice in one step
        @(posedge pclk);
    endtask
    // Start an operation, note its record, poll busy until clear
    task run(input logic [2:0] fl, input logic [1:0] op, input logic [127:0] note);
        if (fl[1:0] == 2'b11) q.push_back(note);
        slow <= 2'($urandom % 3);
        apb(1'b1, `PCD_A_FLAGS, {29'h0, fl});
        apb(1'b1, `PCD_A_CTRL, {29'h0, op, 1'b1});
        repeat (400) begin
            apb(1'b0, `PCD_A_CTRL, 32'h0);
            if (r[0] === 1'b0) break;
        end
        repeat (2) @(posedge pclk);
    endtask
    // Completion record word 0 against the oldest note
    always @(posedge pclk) begin
        if (mem_req && mem_we && mem_ack && mem_addr === CR) begin
            nt = (q.size() > 0) ? q.pop_front() : {64'h1, 64'h2};
            chk(mem_wdata & nt[127:64], nt[63:0]);
        end
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        test_done;
    end
    initial begin
        void'($urandom(32'hE985094F));
        pat = {$urandom, $urandom};
        n = {$urandom, $urandom};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `PCD_A_CREC, CR);
        apb(1'b1, `PCD_A_IMASK, 32'h1);
        apb(1'b1, `PCD_A_PATLO, pat[31:0]);
        apb(1'b1, `PCD_A_PATHI, pat[63:32]);
        apb(1'b1, `PCD_A_SRC1, 32'h200);
        apb(1'b1, `PCD_A_SIZE, 32'd13);
        apb(1'b0, 8'h44, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        // Byte 13 differs but lies past the partial pattern
        pcd_mem_i.m[29'h40] = pat;
        pcd_mem_i.m[29'h41] = pat ^ 64'h0000_FF00_0000_0000;
        run(3'b011, 2'h1, {64'h1FF, 64'h001});
        chk(irq, 1'b1);
        apb(1'b1, `PCD_A_ISTAT, 32'h3);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        // Difference at offset 10; expected bits 7:1 are ignored
        pcd_mem_i.m[29'h41] = pat ^ 64'h0000_0000_00FF_0000;
        apb(1'b1, `PCD_A_EXP, 32'hFF);
        run(3'b111, 2'h1, {MM, 64'h0000_000A_0000_0101});
        apb(1'b1, `PCD_A_EXP, 32'hFE);
        run(3'b111, 2'h1, {MM, 64'h0000_000A_0000_0102});
        // Fault on the second word
        pcd_mem_i.m[29'h41] = pat;
        fault_addr <= 32'h208;
        run(3'b011, 2'h1, {64'h1FF, 64'h003});
        apb(1'b0, `PCD_A_FADDR, 32'h0);
        chk(r, 32'h208);
        // A difference ahead of the fault wins
        pcd_mem_i.m[29'h40] = pat ^ 64'hFF;
        run(3'b011, 2'h1, {MM, 64'h101});
        fault_addr <= 32'hFFFF_FFF8;
        // Masked, and no record without both flags
        apb(1'b1, `PCD_A_IMASK, 32'h0);
        run(3'b001, 2'h1, 128'h0);
        apb(1'b0, `PCD_A_STAT, 32'h0);
        chk({irq, r}, {1'b0, 32'h13});
        // Delta over 16 bytes, second word differs
        pcd_mem_i.m[29'h40] = pat;
        pcd_mem_i.m[29'h41] = ~pat;
        pcd_mem_i.m[29'h60] = pat;
        pcd_mem_i.m[29'h61] = n;
        pcd_mem_i.m[29'hA0] = pat;
        pcd_mem_i.m[29'hA1] = ~pat;
        apb(1'b1, `PCD_A_SRC2, 32'h300);
        apb(1'b1, `PCD_A_SIZE, 32'd16);
        apb(1'b1, `PCD_A_DREC, 32'h400);
        apb(1'b1, `PCD_A_DMAX, 32'h40);
        run(3'b011, 2'h2, {64'h1FF, 64'h101});
        apb(1'b0, `PCD_A_DSIZE, 32'h0);
        chk(r, `PCD_ENTRY_B);
        // Apply to a copy of source one
        apb(1'b1, `PCD_A_SRC2, 32'h500);
        apb(1'b1, `PCD_A_DMAX, `PCD_ENTRY_B);
        run(3'b011, 2'h3, {64'hFF, 64'h01});
        chk({pcd_mem_i.m[29'hA0], pcd_mem_i.m[29'hA1]}, {pat, n});
        // Record overlapping the destination
        apb(1'b1, `PCD_A_DREC, 32'h500);
        run(3'b011, 2'h3, {64'hFF, 64'h12});
        // Creation past the largest delta offset
        apb(1'b1, `PCD_A_SIZE, 32'h0008_0000);
        run(3'b011, 2'h2, {64'hFF, 64'h10});
        chk(q.size(), 0);
        test_done;
    end
endmodule
